/* File: design/adc_ctrl_pkg.sv */
// constants, register map and types for the converter control block
package adc_ctrl_pkg;
    // ****************************************
    // register byte addresses
    // ****************************************
    localparam logic [3:0] result_low_addr = 4'h0;
    localparam logic [3:0] result_high_addr = 4'h4;
    localparam logic [3:0] conversion_control_addr = 4'h8;
    localparam logic [3:0] conversion_clock_select_addr = 4'hC;
    localparam logic [3:0] analog_pin_config_addr = 4'h0;
    localparam logic [7:0] analog_pin_config_offset = 8'h10;
    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int start_bit = 7;
    localparam int busy_bit = 6;
    localparam logic [7:0] control_reset = 8'h40;
    localparam logic [1:0] divider_reset = 2'h0;
    localparam logic [7:0] pin_config_reset = 8'h00;
    localparam logic [1:0] axi_okay = 2'h0;
    localparam logic [1:0] axi_slverr = 2'h2;
    // ****************************************
    // conversion timing
    // ****************************************
    localparam int result_width = 12;
    localparam int conversion_periods = 16;
    localparam logic [5:0] half_div2 = 6'h01;
    localparam logic [5:0] half_div8 = 6'h04;
    localparam logic [5:0] half_div32 = 6'h10;
    localparam logic [1:0] div_code_2 = 2'h0;
    localparam logic [1:0] div_code_8 = 2'h1;
    localparam logic [1:0] div_code_32 = 2'h2;
    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_armed = 3'b010,
        st_convert = 3'b100
    } conv_state_t;
endpackage

/* File: design/conv_clock_if.sv */
// interface between controller and its conversion clock divider
`timescale 1ns/100ps
interface conv_clock_if;
    logic run;
    logic [1:0] divider;
    logic tick;
    modport ctrl (output run, output divider, input tick);
    modport gen (input run, input divider, output tick);
endinterface

/* File: design/conv_clock_gen.sv */
// divides the system clock to a conversion clock period tick
`timescale 1ns/100ps
module conv_clock_gen (
    input wire logic clk,
    input wire logic reset_n,
    conv_clock_if.gen cc
);
    typedef struct packed {
        logic [5:0] count;
        logic tick;
    } gen_state_t;
    gen_state_t s_reg;
    gen_state_t s_next;
    logic [5:0] period;
    always_comb begin
        // code 11 is undefined; it falls back to the slowest rate
        unique case (cc.divider)
            adc_ctrl_pkg::div_code_2: period = adc_ctrl_pkg::half_div2 << 1;
            adc_ctrl_pkg::div_code_8: period = adc_ctrl_pkg::half_div8 << 1;
            default: period = adc_ctrl_pkg::half_div32 << 1;
        endcase
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (!cc.run) begin
            s_next.count = 6'h00;
        end else if (s_reg.count == period - 6'h01) begin
            s_next.count = 6'h00;
            s_next.tick = 1'b1;
        end else begin
            s_next.count = s_reg.count + 6'h01;
        end
    end
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    assign cc.tick = s_reg.tick;
endmodule

/* File: design/adc_ctrl_regs.sv */
// register pair holding the latest conversion result
`timescale 1ns/100ps
module adc_ctrl_regs #(
    parameter int width = 12
) (
    input wire logic clk,
    input wire logic load,
    input wire logic [width-1:0] data_in,
    output logic [width-1:0] data_out
);
    typedef struct packed {
        logic [width-1:0] data;
    } hold_state_t;
    hold_state_t s_reg;
    hold_state_t s_next;
    always_comb begin
        s_next = s_reg;
        if (load) begin
            s_next.data = data_in;
        end
    end
    // no reset: contents are unknown until the first conversion ends
    always_ff @(posedge clk) begin
        s_reg <= s_next;
    end
    assign data_out = s_reg.data;
endmodule

/* File: design/adc_conversion_control.sv */
// AXI4-Lite register block and sequencer around a successive-approximation converter
`timescale 1ns/100ps
module adc_conversion_control #(
    parameter int channels = 8,
    parameter int width = 12
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [width-1:0] core_result,
    output logic core_reset,
    output logic core_sample,
    output logic core_power_down,
    output logic [2:0] core_channel,
    output logic [channels-1:0] analog_pin_select,
    output logic conversion_done_irq
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic aw_held;
        logic [4:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic start;
        logic busy;
        logic [2:0] channel_select;
        logic [1:0] conversion_clock_divider;
        logic [channels-1:0] pins;
        adc_ctrl_pkg::conv_state_t state;
        logic [4:0] periods;
        logic [2:0] run_channel;
        logic [1:0] run_divider;
        logic load;
        logic core_reset;
        logic core_sample;
        logic irq;
        logic awready;
        logic wready;
        logic arready;
        logic power_down;
    } ctrl_state_t;
    ctrl_state_t s_reg;
    ctrl_state_t s_next;
    conv_clock_if cc();
    logic [width-1:0] result;
    logic do_write;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic [3:0] rsel;
    logic wr_control;
    logic wr_clock_select;
    logic wr_pin_config;
    logic wr_bad;
    logic [7:0] control_view;
    logic [7:0] clock_select_view;
    logic [7:0] result_low_view;
    logic [7:0] result_high_view;
    conv_clock_gen u_clock (
        .clk(clk),
        .reset_n(reset_n),
        .cc(cc)
    );
    adc_ctrl_regs #(.width(width)) u_result (
        .clk(clk),
        .load(s_reg.load),
        .data_in(core_result),
        .data_out(result)
    );
    assign cc.run = s_reg.state == adc_ctrl_pkg::st_convert;
    assign cc.divider = s_reg.run_divider;
    // ****************************************
    // address decode and read views
    // ****************************************
    // decoded from the held address, so the master may move awaddr once it has been taken
    assign wr_control = s_reg.aw_addr == 5'(adc_ctrl_pkg::conversion_control_addr);
    assign wr_clock_select = s_reg.aw_addr == 5'(adc_ctrl_pkg::conversion_clock_select_addr);
    assign wr_pin_config = s_reg.aw_addr == 5'(adc_ctrl_pkg::analog_pin_config_offset);
    assign wr_bad = s_reg.aw_addr > 5'(adc_ctrl_pkg::analog_pin_config_offset) || s_reg.aw_addr[1:0] != 2'h0;
    assign result_low_view = {result[3:0], 4'h0};
    assign result_high_view = result[11:4];
    assign control_view = {s_reg.start, s_reg.busy, 3'h0, s_reg.channel_select};
    assign clock_select_view = {6'h00, s_reg.conversion_clock_divider};
    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_next = s_reg;
        s_next.load = 1'b0;
        s_next.irq = 1'b0;
        rbyte = 8'h00;
        rsel = s_axi_araddr[3:0];
        // ****************************************
        // write channel
        // ****************************************
        if (s_axi_awvalid && !s_reg.aw_held) begin
            s_next.aw_held = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_reg.w_held) begin
            s_next.w_held = 1'b1;
            s_next.w_data = s_axi_wdata;
            s_next.w_strb = s_axi_wstrb;
        end
        do_write = s_reg.aw_held && s_reg.w_held && !s_reg.bvalid;
        wbyte = s_reg.w_data[7:0];
        if (do_write) begin
            s_next.aw_held = 1'b0;
            s_next.w_held = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = adc_ctrl_pkg::axi_okay;
            if (s_reg.w_strb[0]) begin
                if (wr_control) begin
                    s_next.start = wbyte[adc_ctrl_pkg::start_bit];
                    s_next.channel_select = wbyte[2:0];
                    // a rising start shows busy at once, before the sequencer has left idle
                    if (wbyte[adc_ctrl_pkg::start_bit] && !s_reg.start) begin
                        s_next.busy = 1'b1;
                    end
                end else if (wr_clock_select) begin
                    s_next.conversion_clock_divider = wbyte[1:0];
                end else if (wr_pin_config) begin
                    s_next.pins = wbyte[channels-1:0];
                end
            end
            if (wr_bad) begin
                s_next.bresp = adc_ctrl_pkg::axi_slverr;
            end
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        // ****************************************
        // read channel
        // ****************************************
        if (s_axi_arvalid && !s_reg.rvalid) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = adc_ctrl_pkg::axi_okay;
            if (s_axi_araddr[4]) begin
                rbyte = 8'(s_reg.pins);
                if (rsel != adc_ctrl_pkg::analog_pin_config_addr) begin
                    s_next.rresp = adc_ctrl_pkg::axi_slverr;
                    rbyte = 8'h00;
                end
            end else begin
                unique case (rsel)
                    adc_ctrl_pkg::result_low_addr: rbyte = result_low_view;
                    adc_ctrl_pkg::result_high_addr: rbyte = result_high_view;
                    adc_ctrl_pkg::conversion_control_addr: rbyte = control_view;
                    adc_ctrl_pkg::conversion_clock_select_addr: rbyte = clock_select_view;
                    default: s_next.rresp = adc_ctrl_pkg::axi_slverr;
                endcase
            end
            s_next.rdata = {24'h000000, rbyte};
        end
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        // ****************************************
        // conversion sequencer
        // ****************************************
        s_next.core_sample = 1'b0;
        unique case (s_reg.state)
            adc_ctrl_pkg::st_idle: begin
                if (s_reg.start) begin
                    s_next.state = adc_ctrl_pkg::st_armed;
                end
            end
            adc_ctrl_pkg::st_armed: begin
                s_next.busy = 1'b1;
                if (!s_reg.start) begin
                    s_next.state = adc_ctrl_pkg::st_convert;
                    s_next.run_channel = s_reg.channel_select;
                    s_next.run_divider = s_reg.conversion_clock_divider;
                    s_next.periods = 5'h00;
                end
            end
            adc_ctrl_pkg::st_convert: begin
                if (s_reg.start) begin
                    s_next.state = adc_ctrl_pkg::st_armed;
                end else if (cc.tick) begin
                    s_next.periods = s_reg.periods + 5'h01;
                    if (s_reg.periods == 5'(adc_ctrl_pkg::conversion_periods - 1)) begin
                        s_next.state = adc_ctrl_pkg::st_idle;
                        // a start written in this same cycle keeps the flag set
                        s_next.busy = s_next.start;
                        s_next.irq = 1'b1;
                        s_next.load = 1'b1;
                        s_next.core_sample = 1'b1;
                    end
                end
            end
        endcase
        s_next.core_reset = s_next.state == adc_ctrl_pkg::st_armed;
        // ready and power-down leave as registered copies, so no output has logic behind its flop
        s_next.awready = !s_next.aw_held;
        s_next.wready = !s_next.w_held;
        s_next.arready = !s_next.rvalid;
        s_next.power_down = ~|s_next.pins;
    end
    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s_reg <= '0;
            s_reg.busy <= adc_ctrl_pkg::control_reset[adc_ctrl_pkg::busy_bit];
            s_reg.conversion_clock_divider <= adc_ctrl_pkg::divider_reset;
            s_reg.pins <= channels'(adc_ctrl_pkg::pin_config_reset);
            s_reg.state <= adc_ctrl_pkg::st_idle;
            s_reg.awready <= 1'b1;
            s_reg.wready <= 1'b1;
            s_reg.arready <= 1'b1;
            s_reg.power_down <= ~|adc_ctrl_pkg::pin_config_reset;
        end else begin
            s_reg <= s_next;
        end
    end
    // ****************************************
    // outputs
    // ****************************************
    assign s_axi_awready = s_reg.awready;
    assign s_axi_wready = s_reg.wready;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = s_reg.arready;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign core_reset = s_reg.core_reset;
    assign core_sample = s_reg.core_sample;
    // mux select held for the whole conversion; undefined high codes not trapped
    assign core_channel = s_reg.run_channel;
    assign analog_pin_select = s_reg.pins;
    assign core_power_down = s_reg.power_down;
    assign conversion_done_irq = s_reg.irq;
endmodule

/* File: verification/adc_ctrl_props.sv */
// port checker for the converter control block
`timescale 1ns/100ps
module adc_ctrl_props #(
    parameter int channels = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic core_reset,
    input wire logic core_sample,
    input wire logic [2:0] core_channel,
    input wire logic core_power_down,
    input wire logic [channels-1:0] analog_pin_select,
    input wire logic conversion_done_irq
);
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    power_down_a:
        assert property (core_power_down == (analog_pin_select == '0)) else $error("power down wrong");
    irq_with_load_a:
        assert property (conversion_done_irq == core_sample) else $error("irq not with load");
    armed_quiet_a:
        assert property (core_reset |-> !core_sample) else $error("load while armed");
    conv_min_a:
        assert property ($fell(core_reset) |-> !core_sample [*8]) else $error("conversion too short");
    conv_ends_a:
        assert property ($fell(core_reset) |-> ##[1:600] core_sample) else $error("conversion never ends");
    channel_hold_a:
        assert property (core_sample |-> $stable(core_channel)) else $error("channel moved");
    read_answer_a:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
    low_nibble_a:
        assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 5'h00 |=> s_axi_rdata[3:0] == 4'h0)
            else $error("low nibble set");
    ctrl_gap_a:
        assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 5'h08 |=> s_axi_rdata[5:3] == 3'h0)
            else $error("control gap set");
endmodule
bind adc_conversion_control adc_ctrl_props #(.channels(channels)) u_props (.clk, .reset_n, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .core_reset, .core_sample, .core_channel,
    .core_power_down, .analog_pin_select, .conversion_done_irq);

/* File: verification/core_model.sv */
// behavioural converter core and input multiplexer
`timescale 1ns/100ps
module core_model (
    input wire logic clk,
    input wire logic core_reset,
    input wire logic core_power_down,
    input wire logic [2:0] core_channel,
    output logic [11:0] core_result
);
    // ****************************************
    // core output
    // ****************************************
    logic [11:0] junk_reg = 12'hA5A;
    // in reset or powered down the output churns so a stale load shows
    always @(posedge clk) junk_reg <= ~junk_reg + 12'h001;
    assign core_result = (core_reset || core_power_down) ? junk_reg : {core_channel, 9'h12C};
endmodule

/* File: verification/tb_top.sv */
// self-checking bench for the converter control block
`timescale 1ns/100ps
module tb_top;
    // ****************************************
    // stimulus and checking
    // ****************************************
    localparam logic [4:0] res_l_a = 5'h00, res_h_a = 5'h04, ctl_a = 5'h08, clk_a = 5'h0C, pin_a = 5'h10;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp, wrsp;
    logic [11:0] core_result;
    logic core_reset, core_sample, core_power_down, conversion_done_irq;
    logic [2:0] core_channel;
    logic [7:0] analog_pin_select;
    int n_mismatch = 0;
    int n_tests = 0;
    always #20 clk = ~clk;
    adc_conversion_control u_dut (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_result,
        .core_reset, .core_sample, .core_power_down, .core_channel, .analog_pin_select, .conversion_done_irq);
    core_model u_core (.clk, .core_reset, .core_power_down, .core_channel, .core_result);
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // bready and rready stay high between transfers, so back-to-back calls never drive them twice in one step
    task axi_write(input logic [4:0] a, input logic [7:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        wrsp = s_axi_bresp;
    endtask
    task axi_read(input logic [4:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask
    task test_reset;
        axi_read(ctl_a);
        check("control", rd, 32'h40);
        axi_read(clk_a);
        check("clock select", rd, 32'h0);
        axi_read(pin_a);
        check("pin config", rd, 32'h0);
        check("power down", core_power_down, 1);
        axi_read(5'h14);
        check("unmapped resp", rsp, adc_ctrl_pkg::axi_slverr);
        axi_write(5'h14, 8'hFF);
        check("unmapped write resp", wrsp, adc_ctrl_pkg::axi_slverr);
        $display("test_reset done");
    endtask
    task test_fields;
        axi_write(ctl_a, 8'h3F);
        check("write resp", wrsp, adc_ctrl_pkg::axi_okay);
        axi_read(ctl_a);
        check("control fields", rd, 32'h47);
        axi_write(clk_a, 8'hFF);
        axi_read(clk_a);
        check("clock fields", rd, 32'h3);
        axi_write(pin_a, 8'hFF);
        check("pins", analog_pin_select, 8'hFF);
        check("powered", core_power_down, 0);
        $display("test_fields done");
    endtask
    task test_convert(input logic [1:0] code, input logic [2:0] ch);
        int n;
        int div;
        div = (code == 2'h0) ? 2 : (code == 2'h1) ? 8 : 32;
        axi_write(clk_a, {6'h0, code});
        axi_write(ctl_a, {5'h10, ch});
        axi_read(ctl_a);
        check("armed flag", rd, {24'h0, 5'h18, ch});
        check("core reset", core_reset, 1);
        axi_write(ctl_a, {5'h00, ch});
        for (n = 0; n < 2000 && core_sample !== 1'b1; n++) @(posedge clk);
        check("duration", (n >= 16 * div && n <= 16 * div + 8), 1);
        check("channel", core_channel, ch);
        check("done request", conversion_done_irq, 1);
        axi_read(ctl_a);
        check("done flag", rd, {24'h0, 5'h00, ch});
        axi_read(res_h_a);
        check("result high", rd, {24'h0, ch, 5'h12});
        axi_read(res_l_a);
        check("result low", rd, 32'hC0);
        $display("test_convert done");
    endtask
    // powering down makes the core output churn, so a result that reloads outside a conversion shows
    task test_hold;
        axi_write(pin_a, 8'h00);
        check("powered down", core_power_down, 1);
        axi_write(ctl_a, 8'h05);
        axi_read(res_h_a);
        check("result held", rd, 32'h12);
        $display("test_hold done");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        test_reset;
        test_fields;
        test_convert(2'h0, 3'h7);
        test_convert(2'h1, 3'h2);
        test_convert(2'h2, 3'h0);
        test_hold;
        give_verdict;
    end
    initial begin
        #800000;
        n_mismatch++;
        give_verdict;
    end
endmodule
